/* src/dwt_pkg.sv */
// dual watchdog package: register map, field positions, reset values, codes.
// assumes a 32-bit apb slave with byte registers in the low lane of each word.
package dwt_pkg;

  // ==========================================================
  // register byte addresses
  localparam logic [7:0] DWT_ADDR_WD1_PERIOD = 8'h00;
  localparam logic [7:0] DWT_ADDR_WD1_MODE   = 8'h04;
  localparam logic [7:0] DWT_ADDR_WD2_MODE   = 8'h08;
  localparam logic [7:0] DWT_ADDR_WD2_KICK   = 8'h0C;
  localparam logic [7:0] DWT_ADDR_IRQ_CTRL   = 8'h10;

  // ==========================================================
  // field positions
  localparam int DWT_WD1_RUN_BIT     = 7;
  localparam int DWT_WD1_WDSEL_BIT   = 4;
  localparam int DWT_WD1_RSTSEL_BIT  = 3;
  localparam int DWT_WD2_ACT_HI_BIT  = 6;
  localparam int DWT_WD2_ACT_LO_BIT  = 5;
  localparam int DWT_WD2_CLK_TOP_BIT = 4;
  localparam int DWT_WD2_CLK_SUB_BIT = 3;
  localparam int DWT_IRQ_MASK_BIT    = 6;

  // ==========================================================
  // reset values, keys and write masks
  localparam logic [7:0] DWT_WD1_PERIOD_RST = 8'h00;
  localparam logic [7:0] DWT_WD1_MODE_RST   = 8'h00;
  localparam logic [7:0] DWT_WD2_MODE_RST   = 8'h67;
  localparam logic [7:0] DWT_WD2_KICK_READ  = 8'h9A;
  localparam logic [7:0] DWT_WD2_KICK_KEY   = 8'hAC;
  localparam logic [7:0] DWT_IRQ_CTRL_RST   = 8'h47;
  localparam logic [7:0] DWT_WD1_MODE_MASK  = 8'h98;
  localparam logic [7:0] DWT_IRQ_CTRL_MASK  = 8'h47;

  // ==========================================================
  // period exponents and counter widths
  localparam int DWT_WD1_EXP_BASE = 13;
  localparam int DWT_WD1_EXP_TOP  = 21;
  localparam int DWT_WD2_EXP_MAIN = 18;
  localparam int DWT_WD2_EXP_SUB  = 9;
  localparam int DWT_WD1_CNT_W    = 21;
  localparam int DWT_WD2_CNT_W    = 25;

  typedef enum logic [1:0] {
    DWT_ACC_IDLE = 2'b00,
    DWT_ACC_WAIT = 2'b01,
    DWT_ACC_DONE = 2'b11
  } dwt_acc_t;

endpackage

/* src/dwt_top.sv */
// dual watchdog block: interval/watchdog timer one and default-start timer two.
// assumes count-clock ticks, standby and cpu clock status arrive synchronous to clk.
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps

module dwt_top
  import dwt_pkg::*;
#(
  parameter int WD1_W = DWT_WD1_CNT_W,
  parameter int WD2_W = DWT_WD2_CNT_W
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  input  wire logic        bit_access,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        main_tick,
  input  wire logic        sub_tick,
  input  wire logic        standby_stop,
  input  wire logic        standby_idle,
  input  wire logic        cpu_on_subclock,
  output logic             wd1_interval_irq,
  output logic [2:0]       wd1_irq_priority,
  output logic             wd1_nmi_request,
  output logic             wd1_reset_request,
  output logic             wd2_nmi_request,
  output logic             wd2_reset_request
);

  // ==========================================================
  // helpers
  function automatic logic [WD1_W-1:0] wd1_last(input logic [2:0] code);
    logic [WD1_W:0] span;
    span = '0;
    if (code == 3'h7) begin
      span[DWT_WD1_EXP_TOP] = 1'b1;
    end else begin
      span[DWT_WD1_EXP_BASE + int'(code)] = 1'b1;
    end
    return WD1_W'(span - 1'b1);
  endfunction

  function automatic logic [WD2_W-1:0] wd2_last(input logic [4:0] field);
    logic [WD2_W:0] span;
    span = '0;
    if (field[DWT_WD2_CLK_SUB_BIT]) begin
      span[DWT_WD2_EXP_SUB + int'(field[2:0])] = 1'b1;
    end else begin
      span[DWT_WD2_EXP_MAIN + int'(field[2:0])] = 1'b1;
    end
    return WD2_W'(span - 1'b1);
  endfunction

  // ==========================================================
  // apb access: one wait state, write commits on the pready edge
  dwt_acc_t acc_reg;
  logic     acc_end;
  logic     commit;
  logic     wr_commit;
  logic     byte_wr;
  logic     mapped;
  logic     sel_period;
  logic     sel_wd1_mode;
  logic     sel_wd2_mode;
  logic     sel_kick;
  logic     sel_irq;

  assign sel_period   = (paddr == DWT_ADDR_WD1_PERIOD);
  assign sel_wd1_mode = (paddr == DWT_ADDR_WD1_MODE);
  assign sel_wd2_mode = (paddr == DWT_ADDR_WD2_MODE);
  assign sel_kick     = (paddr == DWT_ADDR_WD2_KICK);
  assign sel_irq      = (paddr == DWT_ADDR_IRQ_CTRL);
  assign mapped       = sel_period || sel_wd1_mode || sel_wd2_mode || sel_kick || sel_irq;
  // access phase seen in the wait state; registered into pready below
  assign acc_end      = (acc_reg == DWT_ACC_WAIT) && psel && penable;
  assign commit       = psel && penable && pready;
  assign wr_commit    = commit && pwrite && !pslverr;
  // a bit-wide write never counts as a byte write
  assign byte_wr      = pstrb[0] && !bit_access;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_reg <= DWT_ACC_IDLE;
    end else begin
      unique case (acc_reg)
        DWT_ACC_IDLE: if (psel && !penable) acc_reg <= DWT_ACC_WAIT;
        DWT_ACC_WAIT: if (psel && penable) acc_reg <= DWT_ACC_DONE;
        DWT_ACC_DONE: acc_reg <= (psel && !penable) ? DWT_ACC_WAIT : DWT_ACC_IDLE;
        default:      acc_reg <= DWT_ACC_IDLE;
      endcase
    end
  end

  // ==========================================================
  // registers
  logic [7:0] wd1_period_select_reg;
  logic [7:0] wd1_mode_control_reg;
  logic [7:0] wd2_mode_clock_select_reg;
  logic       wd2_written_reg;
  logic [7:0] wd_irq_control_reg;
  logic       kick_good;
  logic       kick_bad;
  logic       wd1_run_write;

  assign wd1_run_write = wr_commit && sel_wd1_mode && pstrb[0]
                      && pwdata[DWT_WD1_RUN_BIT];
  assign kick_good = wr_commit && sel_kick && byte_wr
                  && (pwdata[7:0] == DWT_WD2_KICK_KEY);
  // partial or wrong-value writes are treated as a runaway program
  assign kick_bad  = wr_commit && sel_kick && !kick_good;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wd1_period_select_reg <= DWT_WD1_PERIOD_RST;
    end else if (wr_commit && pstrb[0] && sel_period) begin
      wd1_period_select_reg <= {5'h00, pwdata[2:0]};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wd_irq_control_reg <= DWT_IRQ_CTRL_RST;
    end else if (wr_commit && pstrb[0] && sel_irq) begin
      wd_irq_control_reg <= pwdata[7:0] & DWT_IRQ_CTRL_MASK;
    end
  end

  // mode bits only ever go from 0 to 1
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wd1_mode_control_reg <= DWT_WD1_MODE_RST;
    end else if (wr_commit && pstrb[0] && paddr == DWT_ADDR_WD1_MODE) begin
      wd1_mode_control_reg <= wd1_mode_control_reg | (pwdata[7:0] & DWT_WD1_MODE_MASK);
    end
  end

  logic       wd2_mode_write;

  // only a whole-byte write uses up the single allowed write
  assign wd2_mode_write = wr_commit && byte_wr && sel_wd2_mode && !wd2_written_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wd2_mode_clock_select_reg <= DWT_WD2_MODE_RST;
    end else if (wd2_mode_write) begin
      wd2_mode_clock_select_reg <= pwdata[7:0];
    end
  end

  // once set, nothing short of reset reopens the mode register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wd2_written_reg <= 1'b0;
    end else if (wd2_mode_write) begin
      wd2_written_reg <= 1'b1;
    end
  end

  // ==========================================================
  // watchdog one
  logic [WD1_W-1:0] wd1_count_reg;
  logic [WD1_W-1:0] wd1_count_next;
  logic             wd1_run;
  logic             wd1_step;
  logic             wd1_expire;

  assign wd1_run    = wd1_mode_control_reg[DWT_WD1_RUN_BIT];
  // halted in stop/idle and frozen, not cleared, while the cpu runs on subclock
  assign wd1_step   = wd1_run && main_tick && !standby_stop && !standby_idle
                   && !cpu_on_subclock;
  assign wd1_expire = wd1_step && (wd1_count_reg == wd1_last(wd1_period_select_reg[2:0]));

  // a refresh in the same cycle as an expiry still restarts from zero
  always_comb begin
    wd1_count_next = wd1_count_reg;
    if (wd1_run_write) begin
      wd1_count_next = '0;
    end else if (wd1_expire) begin
      wd1_count_next = '0;
    end else if (wd1_step) begin
      wd1_count_next = wd1_count_reg + WD1_W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wd1_count_reg <= '0;
    end else begin
      wd1_count_reg <= wd1_count_next;
    end
  end

  logic             wd1_watchdog;
  logic             wd1_to_reset;

  assign wd1_watchdog = wd1_mode_control_reg[DWT_WD1_WDSEL_BIT];
  assign wd1_to_reset = wd1_mode_control_reg[DWT_WD1_RSTSEL_BIT];

  // mask gates the request here; priority is only passed on to the controller
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wd1_interval_irq <= 1'b0;
    end else begin
      wd1_interval_irq <= wd1_expire && !wd1_watchdog
                       && !wd_irq_control_reg[DWT_IRQ_MASK_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wd1_nmi_request <= 1'b0;
    end else begin
      wd1_nmi_request <= wd1_expire && wd1_watchdog && !wd1_to_reset;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wd1_reset_request <= 1'b0;
    end else begin
      wd1_reset_request <= wd1_expire && wd1_watchdog && wd1_to_reset;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wd1_irq_priority <= DWT_IRQ_CTRL_RST[2:0];
    end else begin
      wd1_irq_priority <= wd_irq_control_reg[2:0];
    end
  end

  // ==========================================================
  // watchdog two
  logic [WD2_W-1:0] wd2_count_reg;
  logic [WD2_W-1:0] wd2_count_next;
  logic             wd2_on;
  logic             wd2_sub;
  logic             wd2_step;
  logic             wd2_expire;
  logic             wd2_fire;
  logic             wd2_to_reset;

  assign wd2_on       = !wd2_mode_clock_select_reg[DWT_WD2_CLK_TOP_BIT];
  assign wd2_sub      = wd2_mode_clock_select_reg[DWT_WD2_CLK_SUB_BIT];
  // subclock source keeps running through idle and stop
  assign wd2_step     = wd2_on && (wd2_sub ? sub_tick
                      : (main_tick && !standby_stop && !standby_idle));
  assign wd2_expire   = wd2_step && (wd2_count_reg == wd2_last(wd2_mode_clock_select_reg[4:0]));
  assign wd2_fire     = wd2_on && (wd2_expire || kick_bad);
  assign wd2_to_reset = wd2_mode_clock_select_reg[DWT_WD2_ACT_HI_BIT];

  // a key write wins over a step in the same cycle
  always_comb begin
    wd2_count_next = wd2_count_reg;
    if (kick_good || wd2_expire) begin
      wd2_count_next = '0;
    end else if (wd2_step) begin
      wd2_count_next = wd2_count_reg + WD2_W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wd2_count_reg <= '0;
    end else begin
      wd2_count_reg <= wd2_count_next;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wd2_nmi_request <= 1'b0;
    end else begin
      wd2_nmi_request <= wd2_fire && !wd2_to_reset;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wd2_reset_request <= 1'b0;
    end else begin
      wd2_reset_request <= wd2_fire && wd2_to_reset;
    end
  end

  // ==========================================================
  // read data, ready and error, all registered
  logic [7:0] rd_byte;

  // unmapped addresses read as zero and raise pslverr
  always_comb begin
    rd_byte = 8'h00;
    unique case (paddr)
      DWT_ADDR_WD1_PERIOD: rd_byte = wd1_period_select_reg;
      DWT_ADDR_WD1_MODE:   rd_byte = wd1_mode_control_reg;
      DWT_ADDR_WD2_MODE:   rd_byte = wd2_mode_clock_select_reg;
      DWT_ADDR_WD2_KICK:   rd_byte = DWT_WD2_KICK_READ;
      DWT_ADDR_IRQ_CTRL:   rd_byte = wd_irq_control_reg;
      default:             rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= acc_end;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= acc_end && !mapped;
    end
  end

  // zero outside the answer cycle so stale data never lingers on the bus
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= (acc_end && !pwrite) ? {24'h000000, rd_byte} : 32'h0000_0000;
    end
  end

endmodule

/* testbench/dwt_top_asserts.sv */
// checker: bus answer timing and timer event causes at dwt_top ports.
// assumes one clock domain with async high reset.
`timescale 1ns/1ps
module dwt_chk
  import dwt_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        main_tick,
  input wire logic        sub_tick,
  input wire logic        standby_stop,
  input wire logic        standby_idle,
  input wire logic        cpu_on_subclock,
  input wire logic        wd1_interval_irq,
  input wire logic [2:0]  wd1_irq_priority,
  input wire logic        wd1_nmi_request,
  input wire logic        wd1_reset_request,
  input wire logic        wd2_nmi_request,
  input wire logic        wd2_reset_request
);
  logic w1_ev;
  logic w2_ev;
  assign w1_ev = wd1_interval_irq | wd1_nmi_request | wd1_reset_request;
  assign w2_ev = wd2_nmi_request | wd2_reset_request;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // bus
  a_apb_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  a_kick_reads_key: assert property (pready && !pwrite && paddr == DWT_ADDR_WD2_KICK
    |-> prdata == {24'h000000, DWT_WD2_KICK_READ}) else $error("kick read wrong");
  a_unmapped_err: assert property (pready && paddr > DWT_ADDR_IRQ_CTRL |-> pslverr)
    else $error("unmapped access without error");
  a_prio_follows: assert property (pready && pwrite && paddr == DWT_ADDR_IRQ_CTRL
    && pstrb[0] && !pslverr |-> ##2 wd1_irq_priority == $past(pwdata[2:0], 2))
    else $error("priority stale");
  // ==========================================================
  // timer events
  a_wd1_needs_tick: assert property (w1_ev |-> $past(main_tick && !standby_stop
    && !standby_idle && !cpu_on_subclock)) else $error("timer one event while frozen");
  a_wd1_single: assert property (w1_ev |=> !w1_ev)
    else $error("timer one event wider than a cycle");
  a_wd1_one_kind: assert property ($onehot0({wd1_interval_irq, wd1_nmi_request,
    wd1_reset_request})) else $error("timer one raised two kinds");
  a_wd2_cause: assert property (w2_ev |-> $past(main_tick && !standby_stop && !standby_idle
    || sub_tick || pready && pwrite && paddr == DWT_ADDR_WD2_KICK)) else $error("wd2 no cause");
  a_wd2_one_kind: assert property (!(wd2_nmi_request && wd2_reset_request))
    else $error("timer two raised both");
  c_irq: cover property (wd1_interval_irq);
  c_nmi1: cover property (wd1_nmi_request);
  c_rst1: cover property (wd1_reset_request);
  c_nmi2: cover property (wd2_nmi_request);
  c_rst2: cover property (wd2_reset_request);
endmodule

bind dwt_top dwt_chk u_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .main_tick(main_tick), .sub_tick(sub_tick),
  .standby_stop(standby_stop), .standby_idle(standby_idle),
  .cpu_on_subclock(cpu_on_subclock), .wd1_interval_irq(wd1_interval_irq),
  .wd1_irq_priority(wd1_irq_priority), .wd1_nmi_request(wd1_nmi_request),
  .wd1_reset_request(wd1_reset_request), .wd2_nmi_request(wd2_nmi_request),
  .wd2_reset_request(wd2_reset_request));

/* testbench/tb_top.sv */
// bench for dwt_top: registers over apb, both timers, freezes, bad kick.
// assumes dwt_pkg compiled first and the checker bound to the design.
`timescale 1ns/1ps
module tb_top;
  import dwt_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, v;
  logic        pready, pslverr, main_tick = 1'b0, sub_tick = 1'b0;
  logic        standby_stop = 1'b0, cpu_on_subclock = 1'b0;
  logic        standby_idle = 1'b0, bit_access = 1'b0, e;
  logic [3:0]  pstrb = 4'hF;
  logic        wd1_interval_irq, wd1_nmi_request, wd1_reset_request;
  logic        wd2_nmi_request, wd2_reset_request;
  logic [2:0]  wd1_irq_priority;
  logic [7:0]  rstv [5];
  int          bad_count = 0, num_checks = 0, seed;
  int          n_irq = 0, n_nmi1 = 0, n_rst1 = 0, n_nmi2 = 0, n_rst2 = 0;

  always #2 clk = ~clk;
  always @(posedge clk) begin
    n_irq += wd1_interval_irq;
    n_nmi1 += wd1_nmi_request;
    n_rst1 += wd1_reset_request;
    n_nmi2 += wd2_nmi_request;
    n_rst2 += wd2_reset_request;
  end

  dwt_top u_dwt_top (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .bit_access(bit_access),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .main_tick(main_tick), .sub_tick(sub_tick), .standby_stop(standby_stop),
    .standby_idle(standby_idle), .cpu_on_subclock(cpu_on_subclock),
    .wd1_interval_irq(wd1_interval_irq), .wd1_irq_priority(wd1_irq_priority),
    .wd1_nmi_request(wd1_nmi_request), .wd1_reset_request(wd1_reset_request),
    .wd2_nmi_request(wd2_nmi_request), .wd2_reset_request(wd2_reset_request));

  // ==========================================================
  // tasks
  task automatic results;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  // entered just after an edge; holds the request until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      results();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, {24'h000000, x});
  endtask

  task automatic tick(input int n, input logic s);
    repeat (n) begin
      main_tick <= !s;
      sub_tick <= s;
      @(posedge clk);
    end
    main_tick <= 1'b0;
    sub_tick <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // ==========================================================
  // sequence
  initial begin
    seed = 32'h12CD569E;
    rstv = '{DWT_WD1_PERIOD_RST, DWT_WD1_MODE_RST, DWT_WD2_MODE_RST,
             DWT_WD2_KICK_READ, DWT_IRQ_CTRL_RST};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 5; i++) rd(8'(4 * i), rstv[i]);
    apb(1'b0, 8'h20, 32'h0);
    chk(e, 1'b1);
    chk(r, 32'h0);
    // timer two: subclock 2^9, nmi action; second write must not land
    apb(1'b1, DWT_ADDR_WD2_MODE, 32'h08);
    apb(1'b1, DWT_ADDR_WD2_MODE, 32'h1F);
    rd(DWT_ADDR_WD2_MODE, 8'h08);
    apb(1'b1, DWT_ADDR_WD2_KICK, 32'hAC);
    tick(511, 1'b1);
    chk(n_nmi2, 0);
    tick(1, 1'b1);
    chk(n_nmi2, 1);
    apb(1'b1, DWT_ADDR_WD2_KICK, 32'hAC);
    tick(300, 1'b1);
    apb(1'b1, DWT_ADDR_WD2_KICK, 32'hAC);
    tick(300, 1'b1);
    chk(n_nmi2, 1);
    apb(1'b1, DWT_ADDR_WD2_KICK, 32'h55);
    repeat (3) @(posedge clk);
    chk(n_nmi2, 2);
    bit_access <= 1'b1;
    apb(1'b1, DWT_ADDR_WD2_KICK, 32'hAC);
    bit_access <= 1'b0;
    repeat (3) @(posedge clk);
    chk(n_nmi2, 3);
    apb(1'b1, DWT_ADDR_WD2_KICK, 32'hAC);
    standby_stop <= 1'b1;
    standby_idle <= 1'b1;
    tick(512, 1'b1);
    standby_stop <= 1'b0;
    standby_idle <= 1'b0;
    chk(n_nmi2, 4);
    // timer one as interval timer, code 0, unmasked, then masked
    v = $random(seed) & 32'h07;
    apb(1'b1, DWT_ADDR_IRQ_CTRL, v);
    @(posedge clk);
    chk(wd1_irq_priority, v);
    pstrb <= 4'h0;
    apb(1'b1, DWT_ADDR_IRQ_CTRL, 32'h40);
    pstrb <= 4'hF;
    rd(DWT_ADDR_IRQ_CTRL, v[7:0]);
    apb(1'b1, DWT_ADDR_WD1_MODE, 32'h80);
    tick(8191, 1'b0);
    chk(n_irq, 0);
    cpu_on_subclock <= 1'b1;
    tick(($random(seed) & 63) + 1, 1'b0);
    cpu_on_subclock <= 1'b0;
    standby_stop <= 1'b1;
    tick(40, 1'b0);
    standby_stop <= 1'b0;
    standby_idle <= 1'b1;
    tick(40, 1'b0);
    standby_idle <= 1'b0;
    chk(n_irq, 0);
    tick(1, 1'b0);
    chk(n_irq, 1);
    tick(8192, 1'b0);
    chk(n_irq, 2);
    apb(1'b1, DWT_ADDR_WD1_MODE, 32'h00);
    rd(DWT_ADDR_WD1_MODE, 8'h80);
    apb(1'b1, DWT_ADDR_IRQ_CTRL, 32'h40);
    tick(8192, 1'b0);
    chk(n_irq, 2);
    // watchdog mode: refresh, nmi, then reset action
    apb(1'b1, DWT_ADDR_WD1_MODE, 32'h90);
    tick(8000, 1'b0);
    apb(1'b1, DWT_ADDR_WD1_MODE, 32'h90);
    tick(8000, 1'b0);
    chk(n_nmi1, 0);
    tick(192, 1'b0);
    chk(n_nmi1, 1);
    apb(1'b1, DWT_ADDR_WD1_MODE, 32'h98);
    tick(8192, 1'b0);
    chk(n_rst1, 1);
    apb(1'b1, DWT_ADDR_WD1_MODE, 32'h00);
    rd(DWT_ADDR_WD1_MODE, 8'h98);
    // second reset: timer two back to its reset-action default, then disabled
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(DWT_ADDR_WD2_MODE, DWT_WD2_MODE_RST);
    apb(1'b1, DWT_ADDR_WD2_KICK, 32'h00);
    repeat (3) @(posedge clk);
    chk(n_rst2, 1);
    apb(1'b1, DWT_ADDR_WD2_MODE, 32'h1F);
    apb(1'b1, DWT_ADDR_WD2_KICK, 32'h00);
    repeat (3) @(posedge clk);
    chk(n_rst2, 1);
    rd(DWT_ADDR_WD1_MODE, DWT_WD1_MODE_RST);
    results();
  end
endmodule
